//--- rx_channel_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * receive per-channel controller and of the host controller that drives it.
 * Assumes a 40 MHz pclk shared by both ends of the register port.
 */
// Functional notes
// R1 - Host keeps configuration bit 2 cleared.
// R2 - Host sets indirect select before channel access.
// R3 - Reset clears the indirect select bit.
// R4 - Enable on: trunk bytes condition received streams.
// R5 - Enable off: streams pass unmodified.
// R6 - Busy reads one during indirect access.
// R7 - Busy falls on a clock edge.
// R8 - Host polls busy before next access.
// R9 - Indirect access completes within 640 ns.
// R10 - Valid address write starts internal access.
// R11 - Direction bit one reads, zero writes.
// R12 - Indirect write: buffer first, then address.
// R13 - Indirect read: address only; data buffered.
// R14 - 20H-3FH hold PCM control bytes.
// R15 - 40H-5FH hold data trunk bytes.
// R16 - 61H-7FH hold signaling bytes; none slot 0.
// R17 - T1 channels share E1 timeslot addresses.
// R18 - Control byte holds six per-channel fields.
// R19 - Data conditioning replaces PCM; gates clock.
// R20 - Signaling conditioning replaces low signaling nibble.
// R21 - Milliwatt pattern replaces PCM; A or mu.
// R22 - Sign invert flips output PCM MSB.
// R23 - Address writes while busy are ignored.
// R24 - Per-channel bytes have no reset value.
`ifndef RX_CHANNEL_REGS_SVH
`define RX_CHANNEL_REGS_SVH

// ---------------------------------------------------------------
// Device register map
// ---------------------------------------------------------------
`define RX_CFG_OFS 8'h70
`define RX_STATUS_OFS 8'h71
`define RX_ADDR_CTRL_OFS 8'h72
`define RX_DATA_OFS 8'h73
`define RX_CFG_RST 8'h00
`define RX_ADDR_CTRL_RST 8'h00
`define RX_DATA_RST 8'h00
`define CFG_ENABLE_BIT 0
`define CFG_INDIRECT_BIT 1
`define CFG_RSVD_BIT 2
`define STATUS_BUSY_BIT 7
`define ADDR_CTRL_RNW_BIT 7

// ---------------------------------------------------------------
// Internal regions and control byte fields
// ---------------------------------------------------------------
`define REGION_PCM_CTRL 2'h1
`define REGION_DATA_TRUNK 2'h2
`define REGION_SIG_TRUNK 2'h3
`define PCM_TEST_BIT 7
`define PCM_DTRK_BIT 6
`define PCM_STRK_BIT 5
`define PCM_MW_BIT 4
`define PCM_ALAW_BIT 3
`define PCM_MSB_INVERT_BIT 2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PCLK_MHZ 40
`define INDIRECT_ACCESS_NS 640
`define INDIRECT_ACCESS_CYC 5'((`INDIRECT_ACCESS_NS * `PCLK_MHZ) / 1000)

// ---------------------------------------------------------------
// Host controller APB map
// ---------------------------------------------------------------
`define HOST_CMD_OFS 8'h00
`define HOST_STATUS_OFS 8'h04
`define HOST_OP_DIRECT_WR 2'h0
`define HOST_OP_DIRECT_RD 2'h1
`define HOST_OP_INDIRECT_WR 2'h2
`define HOST_OP_INDIRECT_RD 2'h3

`endif

//--- rx_channel_pkg.sv
/*
 * Types shared by the receive per-channel controller and its host.
 * Assumes the constants of rx_channel_regs.svh.
 */
package rx_channel_pkg;

    // ---------------------------------------------------------------
    // Host sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        H_IDLE,
        H_WR_BUF,
        H_WR_CTRL,
        H_POLL,
        H_POLL_WAIT,
        H_READ,
        H_READ_WAIT
    } host_state_t;

endpackage

//--- rx_channel_if.sv
/*
 * Byte-wide register port between the host and the receive per-channel
 * controller. Assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface rx_channel_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic reg_rvalid;

    modport device (
        input reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, reg_rvalid
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        input reg_rdata, reg_rvalid
    );
endinterface

`default_nettype wire

//--- rx_channel_controller.sv
/*
 * Receive per-channel controller: four byte registers, an indirect bank of
 * per-timeslot bytes, and the conditioning of the received PCM and
 * signaling streams.
 * Assumes stream inputs come from logic on pclk and one strobe per request.
 */
// Added by the designer: the byte-wide register port.
`include "rx_channel_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_channel_controller
    import rx_channel_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Register port
    rx_channel_if.device bus,
    // Received stream
    input wire logic rx_in_valid,
    input wire logic [4:0] rx_in_slot,
    input wire logic [7:0] rx_in_pcm,
    input wire logic [7:0] rx_in_sig,
    input wire logic [2:0] rx_mw_phase,
    input wire logic nxds0_mode,
    // Backplane stream
    output logic rx_out_valid,
    output logic [7:0] rx_backplane_pcm_out,
    output logic [7:0] rx_backplane_sig_out,
    output logic rx_backplane_clock_en,
    output logic rx_test_route
);

    // ---------------------------------------------------------------
    // Milliwatt patterns
    // ---------------------------------------------------------------
    function automatic logic [7:0] milliwatt(input logic alaw,
                                             input logic [2:0] ph);
        logic [7:0] v;
        v = 8'h00;
        if (alaw) begin
            case (ph)
                3'h0, 3'h3: v = 8'h34;
                3'h1, 3'h2: v = 8'h21;
                3'h4, 3'h7: v = 8'hB4;
                default: v = 8'hA1;
            endcase
        end else begin
            case (ph)
                3'h0, 3'h3: v = 8'h1E;
                3'h1, 3'h2: v = 8'h0B;
                3'h4, 3'h7: v = 8'h9E;
                default: v = 8'h8B;
            endcase
        end
        return v;
    endfunction

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] addr_ctrl_r;
    logic [7:0] data_r;
    logic busy_r;
    logic [4:0] busy_cnt_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [7:0] pcm_ctrl_mem [0:31];
    logic [7:0] data_trunk_mem [0:31];
    logic [3:0] sig_trunk_mem [0:31];

    logic wr_cfg;
    logic wr_ctrl;
    logic wr_data;
    logic start;
    logic done;
    logic [1:0] region;
    logic [4:0] slot;
    logic [7:0] bank_rd;

    assign wr_cfg = bus.reg_wr && bus.reg_addr == `RX_CFG_OFS;
    assign wr_ctrl = bus.reg_wr && bus.reg_addr == `RX_ADDR_CTRL_OFS;
    assign wr_data = bus.reg_wr && bus.reg_addr == `RX_DATA_OFS;
    // Address writes during an access are dropped to keep it intact
    assign start = wr_ctrl && !busy_r && cfg_r[`CFG_INDIRECT_BIT]
                   && bus.reg_wdata[6:5] != 2'h0; // R10 R23
    assign done = busy_r && busy_cnt_r == 5'h1; // R9
    // Same offsets serve T1 channels 1..24 and E1 timeslots
    assign region = addr_ctrl_r[6:5]; // R17
    assign slot = addr_ctrl_r[4:0];

    always_comb begin
        case (region)
            `REGION_PCM_CTRL: bank_rd = pcm_ctrl_mem[slot]; // R14
            `REGION_DATA_TRUNK: bank_rd = data_trunk_mem[slot]; // R15
            `REGION_SIG_TRUNK: bank_rd = (slot == 5'h0) ? 8'h00
                                 : {4'h0, sig_trunk_mem[slot]}; // R16
            default: bank_rd = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // Configuration
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= `RX_CFG_RST; // R3
        end else if (ce && wr_cfg) begin
            cfg_r <= {5'h00, bus.reg_wdata[2:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ctrl_r <= `RX_ADDR_CTRL_RST;
        end else if (ce && wr_ctrl && !busy_r) begin
            addr_ctrl_r <= bus.reg_wdata; // R23
        end
    end

    // ---------------------------------------------------------------
    // Access timing
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            busy_cnt_r <= 5'h0;
        end else if (ce) begin
            if (start) begin
                busy_r <= 1'b1; // R6
                busy_cnt_r <= `INDIRECT_ACCESS_CYC;
            end else if (done) begin
                busy_r <= 1'b0; // R7
                busy_cnt_r <= 5'h0;
            end else if (busy_r) begin
                busy_cnt_r <= busy_cnt_r - 5'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Data buffer: completion of a read wins over a host write
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= `RX_DATA_RST;
        end else if (ce) begin
            if (done && addr_ctrl_r[`ADDR_CTRL_RNW_BIT]) begin
                data_r <= bank_rd; // R11 R13
            end else if (wr_data) begin
                data_r <= bus.reg_wdata;
            end
        end
    end

    // Bank holds no reset value; software loads it before enabling
    always_ff @(posedge pclk) begin
        if (ce && done && !addr_ctrl_r[`ADDR_CTRL_RNW_BIT]) begin // R11 R24
            case (region)
                `REGION_PCM_CTRL: pcm_ctrl_mem[slot] <= data_r; // R14
                `REGION_DATA_TRUNK: data_trunk_mem[slot] <= data_r; // R15
                `REGION_SIG_TRUNK: begin
                    if (slot != 5'h0) begin
                        sig_trunk_mem[slot] <= data_r[3:0]; // R16
                    end
                end
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Register reads, answered one cycle after the strobe
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (ce) begin
            rvalid_r <= bus.reg_rd;
            if (bus.reg_rd) begin
                case (bus.reg_addr)
                    `RX_CFG_OFS: rdata_r <= cfg_r;
                    `RX_STATUS_OFS: rdata_r <= {busy_r, 7'h00}; // R6
                    `RX_ADDR_CTRL_OFS: rdata_r <= addr_ctrl_r;
                    `RX_DATA_OFS: rdata_r <= data_r;
                    default: rdata_r <= 8'h00;
                endcase
            end
        end
    end

    assign bus.reg_rdata = rdata_r;
    assign bus.reg_rvalid = rvalid_r;

    // ---------------------------------------------------------------
    // Stream conditioning
    // ---------------------------------------------------------------
    logic [7:0] ctl;
    logic en;
    logic [7:0] pcm_nxt;
    logic [7:0] sig_nxt;

    assign ctl = pcm_ctrl_mem[rx_in_slot]; // R18
    assign en = cfg_r[`CFG_ENABLE_BIT];

    // Trunk code outranks milliwatt, which outranks sign inversion
    always_comb begin
        pcm_nxt = rx_in_pcm;
        sig_nxt = rx_in_sig;
        if (en) begin // R4 R5
            if (ctl[`PCM_DTRK_BIT]) begin
                pcm_nxt = data_trunk_mem[rx_in_slot]; // R19
            end else if (ctl[`PCM_MW_BIT]) begin
                pcm_nxt = milliwatt(ctl[`PCM_ALAW_BIT], rx_mw_phase); // R21
            end else if (ctl[`PCM_MSB_INVERT_BIT]) begin
                pcm_nxt = {~rx_in_pcm[7], rx_in_pcm[6:0]}; // R22
            end
            if (ctl[`PCM_STRK_BIT] && rx_in_slot != 5'h0) begin
                sig_nxt = {rx_in_sig[7:4], sig_trunk_mem[rx_in_slot]}; // R20
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_out_valid <= 1'b0;
            rx_backplane_pcm_out <= 8'h00;
            rx_backplane_sig_out <= 8'h00;
            rx_backplane_clock_en <= 1'b1;
            rx_test_route <= 1'b0;
        end else if (ce) begin
            rx_out_valid <= rx_in_valid;
            if (rx_in_valid) begin
                rx_backplane_pcm_out <= pcm_nxt;
                rx_backplane_sig_out <= sig_nxt;
                rx_backplane_clock_en <= !(en && nxds0_mode
                                           && ctl[`PCM_DTRK_BIT]); // R19
                rx_test_route <= en && ctl[`PCM_TEST_BIT]; // R18
            end
        end
    end

endmodule

`default_nettype wire

//--- rx_channel_host.sv
/*
 * Host end: takes commands over APB and runs direct or indirect accesses
 * on the receive per-channel controller's register port.
 * Assumes the device answers each read strobe with one rvalid pulse.
 */
`include "rx_channel_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_channel_host
    import rx_channel_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Register port
    rx_channel_if.host bus
);

    host_state_t state_r;
    logic [1:0] op_r;
    logic [6:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] result_r;
    logic [7:0] bus_addr_r;
    logic [7:0] bus_wdata_r;
    logic bus_wr_r;
    logic bus_rd_r;
    logic apb_wr;
    logic apb_rd;
    logic mapped;

    // ---------------------------------------------------------------
    // APB slave: zero wait states, read data captured at setup
    // ---------------------------------------------------------------
    assign mapped = paddr == `HOST_CMD_OFS || paddr == `HOST_STATUS_OFS;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && apb_rd) begin
            case (paddr)
                `HOST_CMD_OFS: prdata <= {14'h0000, op_r, 1'b0, addr_r,
                                          wdata_r};
                `HOST_STATUS_OFS: prdata <= {16'h0000, result_r, 7'h00,
                                             state_r != H_IDLE};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Command sequencer; a command written while busy is ignored
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= H_IDLE;
            op_r <= 2'h0;
            addr_r <= 7'h00;
            wdata_r <= 8'h00;
            result_r <= 8'h00;
            bus_addr_r <= 8'h00;
            bus_wdata_r <= 8'h00;
            bus_wr_r <= 1'b0;
            bus_rd_r <= 1'b0;
        end else if (ce) begin
            bus_wr_r <= 1'b0;
            bus_rd_r <= 1'b0;
            case (state_r)
                H_IDLE: begin
                    if (apb_wr && paddr == `HOST_CMD_OFS) begin
                        op_r <= pwdata[17:16];
                        addr_r <= pwdata[14:8];
                        wdata_r <= pwdata[7:0];
                        case (pwdata[17:16])
                            `HOST_OP_DIRECT_WR: begin
                                bus_addr_r <= {1'b0, pwdata[14:8]};
                                bus_wdata_r <= pwdata[7:0];
                                bus_wr_r <= 1'b1;
                            end
                            `HOST_OP_DIRECT_RD: state_r <= H_READ;
                            `HOST_OP_INDIRECT_WR: state_r <= H_WR_BUF;
                            default: state_r <= H_WR_CTRL;
                        endcase
                    end
                end
                H_WR_BUF: begin
                    bus_addr_r <= `RX_DATA_OFS; // R12
                    bus_wdata_r <= wdata_r;
                    bus_wr_r <= 1'b1;
                    state_r <= H_WR_CTRL;
                end
                H_WR_CTRL: begin
                    bus_addr_r <= `RX_ADDR_CTRL_OFS;
                    bus_wdata_r <= {op_r == `HOST_OP_INDIRECT_RD,
                                    addr_r}; // R13
                    bus_wr_r <= 1'b1;
                    state_r <= H_POLL;
                end
                H_POLL: begin
                    bus_addr_r <= `RX_STATUS_OFS; // R8
                    bus_rd_r <= 1'b1;
                    state_r <= H_POLL_WAIT;
                end
                H_POLL_WAIT: begin
                    if (bus.reg_rvalid) begin
                        if (bus.reg_rdata[`STATUS_BUSY_BIT]) begin
                            state_r <= H_POLL; // R8
                        end else if (op_r == `HOST_OP_INDIRECT_RD) begin
                            addr_r <= 7'(`RX_DATA_OFS);
                            state_r <= H_READ;
                        end else begin
                            state_r <= H_IDLE;
                        end
                    end
                end
                H_READ: begin
                    bus_addr_r <= {1'b0, addr_r};
                    bus_rd_r <= 1'b1;
                    state_r <= H_READ_WAIT;
                end
                H_READ_WAIT: begin
                    if (bus.reg_rvalid) begin
                        result_r <= bus.reg_rdata;
                        state_r <= H_IDLE;
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    assign bus.reg_addr = bus_addr_r;
    assign bus.reg_wdata = bus_wdata_r;
    assign bus.reg_wr = bus_wr_r;
    assign bus.reg_rd = bus_rd_r;

endmodule

`default_nettype wire

//--- rx_channel_chk.sv
/*
 * Checker for the register port between host and channel controller.
 * Assumes one pclk domain and the constants of rx_channel_regs.svh.
 */
`include "rx_channel_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_channel_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ---------------------------------------------------------------
    // Shadow of configuration and busy time
    // ---------------------------------------------------------------
    logic [2:0] cfg_r;
    logic [4:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cfg_r <= 3'h0;
        else if (reg_wr && reg_addr == 8'h70)
            cfg_r <= reg_wdata[2:0];
    end

    // Refused requests must not restart the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_r <= 5'h0;
        else if (reg_wr && reg_addr == 8'h72 && cfg_r[1] &&
                 reg_wdata[6:5] != 2'h0 && cnt_r == 5'h0)
            cnt_r <= `INDIRECT_ACCESS_CYC;
        else if (cnt_r != 5'h0)
            cnt_r <= cnt_r - 5'h1;
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe got no answer");
    property p_rvalid_cause; reg_rvalid |-> $past(reg_rd); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("answer without read strobe");
    property p_busy_status;
        reg_rvalid && $past(reg_addr) == 8'h71 |->
            reg_rdata[7] == ($past(cnt_r) != 5'h0);
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("busy flag out of step");
    property p_cfg_read;
        reg_rvalid && $past(reg_addr) == 8'h70 |->
            reg_rdata == {5'h0, $past(cfg_r)};
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("configuration readback wrong");
    property p_unmapped;
        reg_rvalid && $past(reg_addr[7:2]) != 6'h1C |-> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rsvd_clear;
        reg_wr && reg_addr == 8'h70 |-> !reg_wdata[2];
    endproperty
    a_rsvd_clear: assert property (p_rsvd_clear)
        else $error("reserved bit written high");
    property p_ind_first; reg_wr && reg_addr == 8'h72 |-> cfg_r[1];
    endproperty
    a_ind_first: assert property (p_ind_first)
        else $error("access before indirect select");
    property p_wait_busy; reg_wr && reg_addr == 8'h72 |-> cnt_r == 5'h0;
    endproperty
    a_wait_busy: assert property (p_wait_busy)
        else $error("access started while busy");
    property p_write_order;
        reg_wr && reg_addr == 8'h72 && !reg_wdata[7] |->
            $past(reg_wr) && $past(reg_addr) == 8'h73;
    endproperty
    a_write_order: assert property (p_write_order)
        else $error("indirect write without buffer load");
endmodule

`default_nettype wire

//--- rx_per_channel_indirect_control_test.sv
/*
 * Bench: host and channel controller joined by rx_channel_if, driven
 * over APB and on the received stream. Assumes ce held high.
 */
`timescale 1ns/1ps
`default_nettype none

module rx_per_channel_indirect_control_test;
    import rx_channel_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, err, vin = 0, nx = 1, vout, ck_en, troute;
    logic [7:0] paddr = 0, pcm = 0, sig = 0, pout, sout;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [4:0] slot = 0;
    logic [2:0] ph = 0;
    logic [7:0] mu [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                           8'h9E, 8'h8B, 8'h8B, 8'h9E};
    logic [7:0] al [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
                           8'hB4, 8'hA1, 8'hA1, 8'hB4};
    logic [7:0] ctl [6] = '{8'h40, 8'h10, 8'h18, 8'h04, 8'h20, 8'h80};
    int n_mismatch = 0, n_compared = 0;

    always #12.5 pclk = ~pclk;

    rx_channel_if bus();
    rx_channel_controller u_rx_channel_controller (.pclk(pclk),
        .presetn(presetn), .ce(1'b1), .bus(bus), .rx_in_valid(vin),
        .rx_in_slot(slot), .rx_in_pcm(pcm), .rx_in_sig(sig),
        .rx_mw_phase(ph), .nxds0_mode(nx), .rx_out_valid(vout),
        .rx_backplane_pcm_out(pout), .rx_backplane_sig_out(sout),
        .rx_backplane_clock_en(ck_en), .rx_test_route(troute));
    rx_channel_host u_rx_channel_host (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus));
    rx_channel_chk u_rx_channel_chk (.pclk(pclk), .presetn(presetn),
        .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
        .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd),
        .reg_rdata(bus.reg_rdata), .reg_rvalid(bus.reg_rvalid));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task test_done;
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            test_done;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    // Host command, then poll until the host reports idle
    task cmd(input logic [1:0] op, input logic [6:0] a, input logic [7:0] d);
        int i;
        apb(1, 8'h00, {14'h0, op, 1'b0, a, d});
        for (i = 0; i < 60; i++) begin
            apb(0, 8'h04, 0);
            if (rd[0] === 1'b0) break;
        end
        if (i == 60) begin
            n_mismatch++;
            test_done;
        end
    endtask

    task send(input logic [4:0] s, input logic [7:0] c, input logic en);
        logic [7:0] p, g, e;
        p = 8'h55 + s;
        g = 8'hC6 ^ s;
        @(posedge pclk);
        vin <= 1; slot <= s; pcm <= p; sig <= g; ph <= s[2:0];
        @(posedge pclk);
        vin <= 0;
        #1;
        e = !en ? p : c[6] ? 8'hC0 | s : c[4] ? (c[3] ? al[s[2:0]] :
            mu[s[2:0]]) : c[2] ? p ^ 8'h80 : p;
        chk(vout, 1);
        chk(pout, e);
        chk(sout, en && c[5] ? {g[7:4], 4'(s)} : g);
        chk(ck_en, !(en && c[6] && nx));
        chk(troute, en && c[7]);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task s_reset;
        int a;
        for (a = 8'h70; a < 8'h74; a++) begin
            cmd(1, a[6:0], 0);
            chk(rd[15:8], 0);
        end
        cmd(1, 7'h10, 0);
        chk(rd[15:8], 0);
        apb(0, 8'h08, 0);
        chk(err, 1);
    endtask

    task s_map;
        static logic [6:0] ad [8] = '{7'h20, 7'h3F, 7'h40, 7'h5F,
                               7'h61, 7'h7F, 7'h38, 7'h60};
        int i;
        cmd(0, 7'h70, 8'h02);
        for (i = 0; i < 8; i++) begin
            cmd(2, ad[i], 8'hA5 ^ i);
            cmd(3, ad[i], 0);
            chk(rd[15:8], i == 7 ? 8'h00 : ad[i] > 7'h60 ?
                (8'h05 ^ i) & 8'h0F : 8'hA5 ^ i);
        end
    endtask

    task s_stream;
        int k, en;
        for (k = 1; k < 7; k++) begin
            cmd(2, 7'h20 + k, ctl[k - 1]);
            cmd(2, 7'h40 + k, 8'hC0 | k);
            cmd(2, 7'h60 + k, 8'hF0 | k);
        end
        // First enabled pass runs outside NxDS0 mode
        for (en = 0; en < 3; en++) begin
            cmd(0, 7'h70, {6'h0, 1'b1, 1'(en != 0)});
            nx <= en != 1;
            for (k = 1; k < 7; k++)
                send(k, ctl[k - 1], en != 0);
        end
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        s_reset;
        s_map;
        s_stream;
        test_done;
    end
endmodule

`default_nettype wire
